// File: verilog/status_led_pkg.sv
// constants for the status led and progress code display block
// assumes a single 40 MHz clock and an APB3 master with 32-bit data
// =====================================================================
// Operation
// [R1] Blink amber at about 1 Hz when any critical threshold is crossed, including the processor hot sensors.
// [R2] Blink amber on regulator hot, too few working fans, or a hard drive fault.
// [R3] Blink amber when the power redundancy sensor reports too few supplies installed.
// [R4] Blink amber when memory is neither spared nor mirrored and correctable errors pass their threshold.
// [R5] Show solid amber on catastrophic error, identity mismatch, first processor absent or thermal trip.
// [R6] Show solid amber on lost power good, lone module failure, unredundant uncorrectable error, trips, second error or 240VA fault.
// [R7] On a video memory test failure or two bad firmware images show solid amber and solid blue chassis id.
// [R8] Through a power-down keep running and hold the sensor state and status led state.
// [R9] If the led is solid green at power-down, turn it off.
// [R10] Boot firmware writes each routine's progress code as that routine begins.
// [R11] Show the progress code on eight leds, led 7 the most significant bit.
// [R12] Hold the last written progress code until the next write.
// [R13] Solid green when healthy and management is up; blink green at about 1 Hz when degraded.
// [R14] Solid amber beats blinking amber, which beats either green state.
package status_led_pkg;

  // =====================================================================
  // timing
  localparam int unsigned CLK_KHZ = 40000;
  localparam int unsigned BLINK_HALF_MS = 500;
  localparam int unsigned BLINK_HALF_CYCLES_DEF = BLINK_HALF_MS * CLK_KHZ;

  // =====================================================================
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SWFAULT = 8'h04;
  localparam logic [7:0] OFS_POST = 8'h08;
  localparam logic [7:0] OFS_ISTAT = 8'h0C;
  localparam logic [7:0] OFS_IMASK = 8'h10;
  localparam logic [7:0] OFS_LIVE = 8'h14;
  localparam logic [7:0] OFS_LEDSTATE = 8'h18;

  // =====================================================================
  // control bits
  localparam int CTRL_W = 4;
  localparam int CTRL_MGMT_READY = 0;
  localparam int CTRL_DEGRADED = 1;
  localparam int CTRL_MEM_SPARING = 2;
  localparam int CTRL_MEM_MIRROR = 3;

  // software-reported fault bits
  localparam int SWF_W = 7;
  localparam int SWF_PSU_SHORT = 0;
  localparam int SWF_CORR_THRESH = 1;
  localparam int SWF_LONE_DIMM = 2;
  localparam int SWF_UNCORR = 3;
  localparam int SWF_240VA = 4;
  localparam int SWF_VIDEO_MEM = 5;
  localparam int SWF_FW_IMAGES = 6;

  // interrupt status bits
  localparam int IRQ_W = 3;
  localparam int IRQ_SOLID = 0;
  localparam int IRQ_BLINK = 1;
  localparam int IRQ_PWR_DOWN = 2;

  // synchronised pin vector
  localparam int PIN_W = 14;
  localparam int PIN_CRIT_THRESH = 0;
  localparam int PIN_PROC_HOT = 1;
  localparam int PIN_REG_HOT = 2;
  localparam int PIN_FAN_MIN = 3;
  localparam int PIN_DRIVE = 4;
  localparam int PIN_CATASTROPHIC = 5;
  localparam int PIN_ID_MISMATCH = 6;
  localparam int PIN_CPU1_ABSENT = 7;
  localparam int PIN_THERM_TRIP = 8;
  localparam int PIN_POWER_GOOD = 9;
  localparam int PIN_DIMM_TRIP = 10;
  localparam int PIN_CHIPSET_TRIP = 11;
  localparam int PIN_SECOND_ERR = 12;
  localparam int PIN_DC_ON = 13;

  localparam int POST_W = 8;

  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_GREEN = 3'b001,
    ST_GREEN_BLINK = 3'b010,
    ST_AMBER_BLINK = 3'b011,
    ST_AMBER = 3'b100
  } status_t;

endpackage : status_led_pkg

// File: verilog/pin_sync_bank.sv
// two-stage synchroniser for a bank of asynchronous level inputs
// assumes the inputs are slow levels; a pulse shorter than one clock may be missed
`timescale 1ns/1ps
module pin_sync_bank #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_q;
      logic sync_q;
      always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= async_in[i];
          sync_q <= meta_q;
        end
      end
      assign sync_out[i] = sync_q;
    end
  endgenerate

endmodule : pin_sync_bank

// File: verilog/blink_timer.sv
// free-running square wave for led blinking
// assumes one clock; the phase flips every HALF_CYCLES clocks
`timescale 1ns/1ps
module blink_timer #(
  parameter int unsigned HALF_CYCLES = 20000000
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // phase
  output logic phase_out
);

  localparam int CW = $clog2(HALF_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(HALF_CYCLES - 1);

  logic [CW-1:0] cnt_q, cnt_d;
  logic phase_q, phase_d;

  always_comb begin
    cnt_d = (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
    phase_d = (cnt_q == LAST) ? ~phase_q : phase_q;
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_q <= '0;
      phase_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      phase_q <= phase_d;
    end
  end

  assign phase_out = phase_q;

  // =====================================================================
  // checks
  phase_flip_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [R13]
    (cnt_q == LAST) |=> (phase_q != $past(phase_q)) && (cnt_q == '0))
    else $error("blink phase did not flip at half period");
  phase_hold_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [R1]
    (cnt_q != LAST) |=> $stable(phase_q))
    else $error("blink phase changed early");

endmodule : blink_timer

// File: verilog/status_led_post_display.sv
// system status led, chassis id led and progress code leds with APB registers
// assumes fault pins are asynchronous levels and the block sits on standby power
`timescale 1ns/1ps
module status_led_post_display #(
  parameter int unsigned BLINK_HALF_CYCLES = status_led_pkg::BLINK_HALF_CYCLES_DEF
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // fault pins, active high except power good
  input wire logic crit_threshold_in,
  input wire logic processor_hot_sensor_in,
  input wire logic regulator_hot_in,
  input wire logic fans_below_min_in,
  input wire logic drive_fault_in,
  input wire logic processor_catastrophic_error_in,
  input wire logic processor_identity_mismatch_in,
  input wire logic cpu1_absent_in,
  input wire logic processor_thermal_trip_in,
  input wire logic power_good_in,
  input wire logic memory_thermal_trip_in,
  input wire logic chipset_thermal_trip_in,
  input wire logic processor_second_error_signal_in,
  input wire logic dc_power_on_in,
  // leds and interrupt
  output logic status_green_out,
  output logic status_amber_out,
  output logic chassis_id_blue_out,
  output logic [status_led_pkg::POST_W-1:0] post_leds_out,
  output logic irq_out
);
  import status_led_pkg::*;

  // =====================================================================
  // reset release
  logic rst_meta_q;
  logic rst_n;

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // =====================================================================
  // pin synchronisers and blink source
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_s;
  logic blink_phase;

  assign pin_raw = {dc_power_on_in, processor_second_error_signal_in, chipset_thermal_trip_in,
                    memory_thermal_trip_in, power_good_in, processor_thermal_trip_in, cpu1_absent_in,
                    processor_identity_mismatch_in, processor_catastrophic_error_in, drive_fault_in,
                    fans_below_min_in, regulator_hot_in, processor_hot_sensor_in, crit_threshold_in};

  pin_sync_bank #(.WIDTH(PIN_W)) u_sync (
    .clk_in(mclk_in),
    .rst_b_in(rst_n),
    .async_in(pin_raw),
    .sync_out(pin_s)
  );

  blink_timer #(.HALF_CYCLES(BLINK_HALF_CYCLES)) u_blink (
    .clk_in(mclk_in),
    .rst_b_in(rst_n),
    .phase_out(blink_phase)
  );

  // =====================================================================
  // registers and state
  logic [CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [SWF_W-1:0] swf_q, swf_d;
  logic [POST_W-1:0] post_q, post_d;
  logic [IRQ_W-1:0] istat_q, istat_d, imask_q, imask_d, events;
  logic [PIN_W-1:0] live_q, live_d;
  logic solid_prev_q, blink_prev_q, dc_prev_q;
  status_t state_q, state_d;
  logic green_q, green_d, amber_q, amber_d, blue_q, blue_d, irq_q, irq_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;

  logic dc_on, non_redundant, blink_fault, solid_fault, id_fault;
  logic access, done, wr, mapped;
  logic [31:0] rdata;

  // =====================================================================
  // fault classification
  always_comb begin
    dc_on = pin_s[PIN_DC_ON];
    // sensor snapshot freezes while powered down
    live_d = dc_on ? pin_s : live_q; // [R8]
    non_redundant = !ctrl_q[CTRL_MEM_SPARING] && !ctrl_q[CTRL_MEM_MIRROR];
    id_fault = swf_q[SWF_VIDEO_MEM] || swf_q[SWF_FW_IMAGES]; // [R7]
    blink_fault = live_q[PIN_CRIT_THRESH] || live_q[PIN_PROC_HOT] // [R1]
                  || live_q[PIN_REG_HOT] || live_q[PIN_FAN_MIN] || live_q[PIN_DRIVE] // [R2]
                  || swf_q[SWF_PSU_SHORT] // [R3]
                  || (swf_q[SWF_CORR_THRESH] && non_redundant); // [R4]
    solid_fault = live_q[PIN_CATASTROPHIC] || live_q[PIN_ID_MISMATCH] // [R5]
                  || live_q[PIN_CPU1_ABSENT] || live_q[PIN_THERM_TRIP] // [R5]
                  || (live_q[PIN_DC_ON] && !live_q[PIN_POWER_GOOD]) // [R6]
                  || live_q[PIN_DIMM_TRIP] || live_q[PIN_CHIPSET_TRIP] || live_q[PIN_SECOND_ERR] // [R6]
                  || swf_q[SWF_LONE_DIMM] || (swf_q[SWF_UNCORR] && non_redundant) // [R6]
                  || swf_q[SWF_240VA] || id_fault; // [R6]
  end

  // =====================================================================
  // status led state
  always_comb begin
    state_d = state_q;
    if (dc_on) begin
      if (solid_fault) begin
        state_d = ST_AMBER; // [R14]
      end else if (blink_fault) begin
        state_d = ST_AMBER_BLINK; // [R14]
      end else if (ctrl_q[CTRL_DEGRADED]) begin
        state_d = ST_GREEN_BLINK; // [R13]
      end else if (ctrl_q[CTRL_MGMT_READY]) begin
        state_d = ST_GREEN; // [R13]
      end else begin
        state_d = ST_OFF;
      end
    end else if (state_q == ST_GREEN) begin
      state_d = ST_OFF; // [R9]
    end
    // any other state is kept across the power-down, blink included
    green_d = (state_q == ST_GREEN) || ((state_q == ST_GREEN_BLINK) && blink_phase); // [R13]
    amber_d = (state_q == ST_AMBER) || ((state_q == ST_AMBER_BLINK) && blink_phase); // [R1]
    blue_d = id_fault; // [R7]
  end

  // =====================================================================
  // apb slave: one wait state, answer on the second access cycle
  always_comb begin
    access = psel_in && penable_in;
    done = access && pready_q;
    wr = done && pwrite_in;
    mapped = 1'b1;
    rdata = 32'h0000_0000;
    case (paddr_in)
      OFS_CTRL: rdata[CTRL_W-1:0] = ctrl_q;
      OFS_SWFAULT: rdata[SWF_W-1:0] = swf_q;
      OFS_POST: rdata[POST_W-1:0] = post_q;
      OFS_ISTAT: rdata[IRQ_W-1:0] = istat_q;
      OFS_IMASK: rdata[IRQ_W-1:0] = imask_q;
      OFS_LIVE: rdata[PIN_W-1:0] = live_q;
      OFS_LEDSTATE: rdata[$bits(status_t)-1:0] = state_q;
      default: mapped = 1'b0;
    endcase
    pready_d = access && !pready_q;
    pslverr_d = access && !pready_q && !mapped;
    prdata_d = (access && !pready_q) ? rdata : prdata_q;

    ctrl_d = (wr && paddr_in == OFS_CTRL) ? pwdata_in[CTRL_W-1:0] : ctrl_q;
    swf_d = (wr && paddr_in == OFS_SWFAULT) ? pwdata_in[SWF_W-1:0] : swf_q;
    post_d = (wr && paddr_in == OFS_POST) ? pwdata_in[POST_W-1:0] : post_q; // [R12]
    imask_d = (wr && paddr_in == OFS_IMASK) ? pwdata_in[IRQ_W-1:0] : imask_q;

    events = '0;
    events[IRQ_SOLID] = solid_fault && !solid_prev_q;
    events[IRQ_BLINK] = blink_fault && !blink_prev_q;
    events[IRQ_PWR_DOWN] = dc_prev_q && !dc_on;
    // a new event in the clearing cycle survives the clear
    istat_d = istat_q;
    if (wr && paddr_in == OFS_ISTAT) begin
      istat_d = istat_q & ~pwdata_in[IRQ_W-1:0];
    end
    istat_d = istat_d | events;
    irq_d = |(istat_q & imask_q);
  end

  // =====================================================================
  // registering
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= '0;
      swf_q <= '0;
      post_q <= '0;
      istat_q <= '0;
      imask_q <= '0;
      live_q <= '0;
      solid_prev_q <= 1'b0;
      blink_prev_q <= 1'b0;
      dc_prev_q <= 1'b0;
      state_q <= ST_OFF;
      green_q <= 1'b0;
      amber_q <= 1'b0;
      blue_q <= 1'b0;
      irq_q <= 1'b0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      ctrl_q <= ctrl_d;
      swf_q <= swf_d;
      post_q <= post_d;
      istat_q <= istat_d;
      imask_q <= imask_d;
      live_q <= live_d;
      solid_prev_q <= solid_fault;
      blink_prev_q <= blink_fault;
      dc_prev_q <= dc_on;
      state_q <= state_d;
      green_q <= green_d;
      amber_q <= amber_d;
      blue_q <= blue_d;
      irq_q <= irq_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  // bit 7 of the code lands on led 7
  assign post_leds_out = post_q; // [R11]
  assign status_green_out = green_q;
  assign status_amber_out = amber_q;
  assign chassis_id_blue_out = blue_q;
  assign irq_out = irq_q;
  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;
  assign prdata_out = prdata_q;

  // =====================================================================
  // checks
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n);

  logic post_wr;
  assign post_wr = wr && (paddr_in == OFS_POST);

  crit_blink_a: assert property (dc_on && live_q[PIN_CRIT_THRESH] && !solid_fault // [R1]
    |=> state_q == ST_AMBER_BLINK)
    else $error("critical threshold did not blink amber");
  reg_hot_a: assert property (dc_on && live_q[PIN_REG_HOT] && !solid_fault // [R2]
    |=> state_q == ST_AMBER_BLINK)
    else $error("regulator hot did not blink amber");
  fan_min_a: assert property (dc_on && live_q[PIN_FAN_MIN] && !solid_fault // [R2]
    |=> state_q == ST_AMBER_BLINK)
    else $error("fan shortfall did not blink amber");
  psu_short_a: assert property (dc_on && swf_q[SWF_PSU_SHORT] && !solid_fault // [R3]
    |=> state_q == ST_AMBER_BLINK)
    else $error("power redundancy shortfall did not blink amber");
  corr_err_a: assert property (dc_on && swf_q[SWF_CORR_THRESH] && !solid_fault // [R4]
    && !ctrl_q[CTRL_MEM_SPARING] && !ctrl_q[CTRL_MEM_MIRROR] |=> state_q == ST_AMBER_BLINK)
    else $error("correctable error threshold did not blink amber");
  cat_err_a: assert property (dc_on && live_q[PIN_CATASTROPHIC] // [R5]
    |=> ##1 amber_q && !green_q)
    else $error("catastrophic error did not light solid amber");
  cpu_absent_a: assert property (dc_on && live_q[PIN_CPU1_ABSENT] // [R5]
    |=> state_q == ST_AMBER)
    else $error("missing first processor did not light solid amber");
  power_fault_a: assert property (dc_on && live_q[PIN_DC_ON] && !live_q[PIN_POWER_GOOD] // [R6]
    |=> state_q == ST_AMBER)
    else $error("power good loss did not light solid amber");
  id_blue_a: assert property (dc_on && swf_q[SWF_FW_IMAGES] // [R7]
    |=> blue_q ##1 amber_q)
    else $error("firmware image fault missing blue or amber");
  hold_down_a: assert property (!dc_on && state_q != ST_GREEN // [R8]
    |=> $stable(state_q) && $stable(live_q))
    else $error("state changed while powered down");
  green_off_a: assert property (!dc_on && state_q == ST_GREEN // [R9]
    |=> state_q == ST_OFF ##1 !green_q)
    else $error("solid green not turned off at power-down");
  post_show_a: assert property (post_wr // [R11]
    |=> post_leds_out == $past(pwdata_in[POST_W-1:0]))
    else $error("progress code not shown");
  post_hold_a: assert property (!post_wr |=> $stable(post_leds_out)) // [R12]
    else $error("progress code changed without a write");
  healthy_a: assert property (dc_on && !solid_fault && !blink_fault && !ctrl_q[CTRL_DEGRADED] // [R13]
    && ctrl_q[CTRL_MGMT_READY] |=> state_q == ST_GREEN ##1 green_q)
    else $error("healthy system not solid green");
  priority_a: assert property (dc_on && solid_fault && (blink_fault || ctrl_q[CTRL_DEGRADED]) // [R14]
    |=> state_q == ST_AMBER)
    else $error("solid amber lost priority");
  blink_wins_a: assert property (dc_on && !solid_fault && blink_fault && ctrl_q[CTRL_DEGRADED] // [R14]
    |=> state_q == ST_AMBER_BLINK)
    else $error("blinking amber lost priority to green");
  // a clear written in the same cycle as a new event must not lose the event
  set_wins_a: assert property (events[IRQ_SOLID] |=> istat_q[IRQ_SOLID])
    else $error("solid class event lost");

  solid_cov_c: cover property (state_q == ST_AMBER ##1 !dc_on [*2]);
  degraded_cov_c: cover property (state_q == ST_GREEN_BLINK && green_q);
  post_cov_c: cover property (post_wr ##[1:20] post_wr);
  blink_cov_c: cover property (state_q == ST_AMBER_BLINK && amber_q);
  irq_cov_c: cover property (!irq_q ##1 irq_q);

endmodule : status_led_post_display

// File: verification/fault_source_model.sv
// model of the platform fault sensors and power-state pins seen by the status block
// assumes the bench calls drive() just after a rising clock edge
`timescale 1ns/1ps
module fault_source_model (
  // fault, power good and dc-on levels, bit order as the live snapshot
  output logic [status_led_pkg::PIN_W-1:0] pins_out
);
  import status_led_pkg::*;

  // =====================================================================
  // levels
  // idle: no faults, power good high, system in the on state
  logic [PIN_W-1:0] pins_q = 14'h2200;

  assign pins_out = pins_q;

  // sensors hold a level until the condition goes away, no glitches
  task automatic drive(input logic [PIN_W-1:0] v);
    pins_q <= v;
  endtask : drive
endmodule : fault_source_model

// File: verification/status_led_and_post_code_display_tb.sv
// self-checking bench for the status led and progress code block
// assumes the blink half period is cut to 4 clocks; registers reached over APB
`timescale 1ns/1ps
module status_led_and_post_code_display_tb;
  import status_led_pkg::*;

  // =====================================================================
  // signals
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [13:0] pins;
  logic green, amber, blue, irq;
  logic [7:0] post;
  int failures = 0;
  int compares = 0;
  localparam logic [13:0] IDLE = 14'h2200;
  int solid_pins[7] = '{5, 6, 7, 8, 10, 11, 12};

  initial begin
    forever #12.5 mclk = ~mclk;
  end

  fault_source_model fault_source_model_inst (.pins_out(pins));

  status_led_post_display #(.BLINK_HALF_CYCLES(4)) status_led_post_display_inst (
    .mclk_in(mclk), .rst_b_in(rst_b),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .crit_threshold_in(pins[0]), .processor_hot_sensor_in(pins[1]), .regulator_hot_in(pins[2]),
    .fans_below_min_in(pins[3]), .drive_fault_in(pins[4]), .processor_catastrophic_error_in(pins[5]),
    .processor_identity_mismatch_in(pins[6]), .cpu1_absent_in(pins[7]), .processor_thermal_trip_in(pins[8]),
    .power_good_in(pins[9]), .memory_thermal_trip_in(pins[10]), .chipset_thermal_trip_in(pins[11]),
    .processor_second_error_signal_in(pins[12]), .dc_power_on_in(pins[13]),
    .status_green_out(green), .status_amber_out(amber), .chassis_id_blue_out(blue),
    .post_leds_out(post), .irq_out(irq)
  );

  // =====================================================================
  // checking and closing
  task automatic end_of_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // =====================================================================
  // apb master: one setup, access until pready, then one idle cycle
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      $display("[FAIL] %0t no pready", $time);
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    check(r, exp);
    check({31'h0, e}, 32'h0000_0000);
  endtask : rd_chk

  task automatic pins_wait(input logic [13:0] v);
    fault_source_model_inst.drive(v);
    repeat (8) @(posedge mclk);
  endtask : pins_wait

  // samples one led over four blink half periods; a blinking led is seen both lit and dark
  task automatic blink_chk(input logic which_amber);
    int hi;
    hi = 0;
    repeat (16) begin
      @(posedge mclk);
      hi += int'(which_amber ? amber : green);
    end
    check({31'h0, hi > 0 && hi < 16}, 32'h0000_0001);
  endtask : blink_chk

  // =====================================================================
  // main sequence
  initial begin
    logic [31:0] r;
    logic e;
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    rd_chk(OFS_LEDSTATE, 32'h0000_0000);
    check({28'h0, green, amber, blue, irq}, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0001);
    repeat (3) @(posedge mclk);
    rd_chk(OFS_LEDSTATE, 32'(ST_GREEN));
    check({30'h0, green, amber}, 32'h0000_0002);
    wr(OFS_CTRL, 32'h0000_0003);
    rd_chk(OFS_LEDSTATE, 32'(ST_GREEN_BLINK));
    blink_chk(1'b0);
    // blink class pins, each with degraded also set, so blinking amber must win
    for (int i = 0; i < 5; i++) begin
      pins_wait(IDLE | (14'h0001 << i));
      rd_chk(OFS_LEDSTATE, 32'(ST_AMBER_BLINK));
    end
    blink_chk(1'b1);
    check({31'h0, green}, 32'h0000_0000);
    pins_wait(IDLE | 14'h0001 | (14'h0001 << 5));
    rd_chk(OFS_LEDSTATE, 32'(ST_AMBER));
    pins_wait(IDLE);
    wr(OFS_CTRL, 32'h0000_0001);
    for (int b = 0; b < 7; b++) begin
      wr(OFS_SWFAULT, 32'h0000_0001 << b);
      repeat (3) @(posedge mclk);
      rd_chk(OFS_LEDSTATE, b < 2 ? 32'(ST_AMBER_BLINK) : 32'(ST_AMBER));
      check({31'h0, blue}, {31'h0, b >= 5});
    end
    // with sparing on, crossing the correctable threshold is not an alarm
    wr(OFS_CTRL, 32'h0000_0005);
    wr(OFS_SWFAULT, 32'h0000_0002);
    rd_chk(OFS_LEDSTATE, 32'(ST_GREEN));
    wr(OFS_SWFAULT, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0001);
    foreach (solid_pins[i]) begin
      pins_wait(IDLE | (14'h0001 << solid_pins[i]));
      rd_chk(OFS_LEDSTATE, 32'(ST_AMBER));
      check({30'h0, green, amber}, 32'h0000_0001);
    end
    pins_wait(IDLE & ~(14'h0001 << PIN_POWER_GOOD));
    rd_chk(OFS_LEDSTATE, 32'(ST_AMBER));
    pins_wait(IDLE);
    // interrupts: solid class unmasked, blink class masked
    wr(OFS_ISTAT, 32'h0000_0007);
    wr(OFS_IMASK, 32'h0000_0001);
    repeat (2) @(posedge mclk);
    check({31'h0, irq}, 32'h0000_0000);
    pins_wait(IDLE | (14'h0001 << PIN_CATASTROPHIC));
    check({31'h0, irq}, 32'h0000_0001);
    pins_wait(IDLE);
    rd_chk(OFS_ISTAT, 32'h0000_0001);
    wr(OFS_ISTAT, 32'h0000_0001);
    repeat (2) @(posedge mclk);
    check({31'h0, irq}, 32'h0000_0000);
    pins_wait(IDLE | 14'h0004);
    rd_chk(OFS_ISTAT, 32'h0000_0002);
    check({31'h0, irq}, 32'h0000_0000);
    pins_wait(IDLE);
    // unmapped offset is refused, read-only state ignores writes
    apb(1'b0, 8'h1C, 32'h0000_0000, r, e);
    check({r[30:0], e}, 32'h0000_0001);
    wr(OFS_LEDSTATE, 32'h0000_0004);
    rd_chk(OFS_LEDSTATE, 32'(ST_GREEN));
    // power-down from healthy turns the led off; a blinking state survives power-down
    pins_wait(IDLE & ~(14'h0001 << PIN_DC_ON));
    rd_chk(OFS_LEDSTATE, 32'(ST_OFF));
    check({30'h0, green, amber}, 32'h0000_0000);
    // the earlier blink event is still pending, the power-down adds its own
    rd_chk(OFS_ISTAT, 32'h0000_0006);
    check({31'h0, irq}, 32'h0000_0000);
    pins_wait(IDLE | 14'h0008);
    pins_wait((IDLE | 14'h0008) & ~(14'h0001 << PIN_DC_ON));
    pins_wait(IDLE & ~(14'h0001 << PIN_DC_ON));
    rd_chk(OFS_LEDSTATE, 32'(ST_AMBER_BLINK));
    blink_chk(1'b1);
    pins_wait(IDLE);
    // progress codes: every bit position lands on its own led and holds
    for (int k = 0; k < 8; k++) begin
      wr(OFS_POST, 32'h0000_0001 << k);
      check({24'h0, post}, 32'h0000_0001 << k);
    end
    wr(OFS_POST, 32'h0000_00A5);
    repeat (40) @(posedge mclk);
    check({24'h0, post}, 32'h0000_00A5);
    rd_chk(OFS_POST, 32'h0000_00A5);
    end_of_test();
  end
endmodule : status_led_and_post_code_display_tb
